//--- logic/scx_card_serial.sv
// Smart card character transmitter and receiver with Wishbone registers
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module scx_card_serial (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [4:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic       engTxWrite,
    input  wire logic [7:0] engTxData,
    input  wire logic       engRxRead,
    output logic [7:0]      rxData,
    output logic            txEmptyIrq,
    output logic            txDoneIrq,
    output logic            rxFullIrq,
    output logic            rxFaultIrq,
    output logic            engTxReq,
    output logic            engRxReq,
    input  wire logic       cardDataIn,
    output logic            cardDataOut,
    output logic            cardDataOe,
    output logic            cardClk
);
    import scx_pkg::*;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdat;
        logic [7:0] fmt;
        logic [7:0] ctl;
        logic [7:0] tx_holding_reg;
        logic [7:0] rx_holding_reg;
        logic       cardMode;
        logic [7:0] div;
        logic [7:0] flags;
        logic [7:0] seen;
        logic       sync1;
        logic       sync2;
        logic       linePrev;
        logic [7:0] divCnt;
        logic [7:0] sckCnt;
        logic       sckRun;
        logic       sckPh;
        scx_link_t  st;
        logic [8:0] shifter;
        logic [3:0] bitIdx;
        logic [9:0] tickCnt;
        logic       err;
        logic       drvLow;
    } scx_state_t;

    scx_state_t s;
    scx_state_t next_s;

    function automatic logic [9:0] ratioTicks(input logic [1:0] code);
        case (code)
            2'd0:    ratioTicks = RATIO_0;
            2'd1:    ratioTicks = RATIO_1;
            2'd2:    ratioTicks = RATIO_2;
            default: ratioTicks = RATIO_3;
        endcase
    endfunction : ratioTicks

    // Parity bit of a character, odd format inverts it
    function automatic logic charParity(input logic [7:0] d,
                                        input logic       odd);
        charParity = (^d) ^ odd;
    endfunction : charParity

    // Register read decode by word index
    function automatic logic [7:0] readReg(input logic [2:0] idx);
        case (idx)
            ADR_FORMAT:  readReg = s.fmt;
            ADR_CONTROL: readReg = s.ctl;
            ADR_TXHOLD:  readReg = s.tx_holding_reg;
            ADR_STATUS:  readReg = s.flags;
            ADR_RXHOLD:  readReg = s.rx_holding_reg;
            ADR_CARD:    readReg = {7'h00, s.cardMode};
            ADR_DIVIDER: readReg = s.div;
            default:     readReg = 8'h00;
        endcase
    endfunction : readReg

    logic       busHit;
    logic       busWrite;
    logic [2:0] regIdx;
    logic       tick;
    logic       sckTick;
    logic       faultAny;
    logic [9:0] halfEtu;
    logic       midBit;
    logic       endBit;
    logic       txReqRaw;

    assign busHit   = wb_cyc_i & wb_stb_i;
    assign busWrite = busHit & wb_we_i & s.ack & wb_sel_i[0];
    assign regIdx   = wb_adr_i[4:2];
    assign tick     = (s.divCnt == s.div);
    // Card clock has its own counter so a restart never bends an etu
    assign sckTick  = (s.sckCnt == s.div);
    assign halfEtu  = ratioTicks(s.fmt[1:0]);
    // Sample mid-bit; one etu is two ticks per basic clock
    // mid-bit sampling
    assign midBit   = tick & (s.tickCnt == halfEtu - 10'd1);
    assign endBit   = tick & (s.tickCnt == {halfEtu[8:0], 1'b0} - 10'd1);

    always_comb begin
        logic [7:0] clr;
        logic [7:0] set;
        logic       parOk;
        clr    = 8'h00;
        set    = 8'h00;
        parOk  = 1'b0;
        next_s = s;

        // Two flops before the line is read; linePrev finds falls
        next_s.sync1    = cardDataIn;
        next_s.sync2    = s.sync1;
        next_s.linePrev = s.sync2;

        // Bus slave: ack one cycle after request, drop it next cycle
        next_s.ack = busHit & ~s.ack;
        if (busHit && !s.ack) begin
            next_s.rdat = readReg(regIdx);
        end

        if (busHit && s.ack && !wb_we_i && regIdx == ADR_STATUS) begin
            next_s.seen = s.seen | s.flags;
        end
        if (busWrite) begin
            case (regIdx)
                ADR_FORMAT:  next_s.fmt = wb_dat_i[7:0];
                ADR_CONTROL: next_s.ctl = wb_dat_i[7:0];
                ADR_TXHOLD:  next_s.tx_holding_reg = wb_dat_i[7:0];
                ADR_CARD:    next_s.cardMode = wb_dat_i[0];
                ADR_DIVIDER: next_s.div = wb_dat_i[7:0];
                ADR_STATUS: begin
                    // clear only after reading 1, writing 0
                    clr = s.seen & ~wb_dat_i[7:0] & 8'hFE;
                    next_s.seen = 8'h00;
                end
                default: ;
            endcase
        end

        // Clearing empty drops done with it
        if (clr[ST_TXEMPTY]) begin
            clr[ST_TXDONE] = 1'b1;
        end
        // engine write clears empty and done
        if (engTxWrite) begin
            next_s.tx_holding_reg = engTxData;
            clr[ST_TXEMPTY] = 1'b1;
            clr[ST_TXDONE]  = 1'b1;
        end
        if (engRxRead) begin
            clr[ST_RXFULL] = 1'b1;
        end

        // Card clock divider and output control
        next_s.divCnt = tick ? 8'h00 : s.divCnt + 8'h01;
        next_s.sckCnt = sckTick ? 8'h00 : s.sckCnt + 8'h01;
        if (s.ctl[CT_CLKON] && !s.sckRun) begin
            // restart divider so first pulse is full width
            next_s.sckRun = 1'b1;
            next_s.sckPh  = 1'b1;
            next_s.sckCnt = 8'h00;
        end else if (s.sckRun && sckTick) begin
            next_s.sckPh = ~s.sckPh;
            // stop only at the end of a full period
            if (!s.ctl[CT_CLKON] && !s.sckPh) begin
                next_s.sckRun = 1'b0;
            end
        end
        // without hold mode the clock stops at once
        if (!s.ctl[CT_CLKON] && !s.fmt[FM_HOLD]) begin
            next_s.sckRun = 1'b0;
        end

        if (tick) begin
            next_s.tickCnt = endBit ? 10'd0 : s.tickCnt + 10'd1;
        end
        if (endBit) begin
            next_s.bitIdx = s.bitIdx + 4'd1;
        end


        // Link sequencer
        case (s.st)
            LINK_IDLE: begin
                next_s.drvLow = 1'b0;
                next_s.tickCnt = 10'd0;
                next_s.bitIdx  = 4'd0;
                // Start only on a tick so slot 0 is a full etu
                // pending byte starts transmission
                if (s.ctl[CT_TXON] && !s.flags[ST_TXEMPTY] && tick) begin
                    next_s.st      = LINK_TX;
                    next_s.shifter = {charParity(s.tx_holding_reg, s.fmt[FM_ODD]),
                                      s.tx_holding_reg};
                    next_s.err     = 1'b0;
                    next_s.drvLow  = 1'b1;
                end else if (s.ctl[CT_RXON] && s.linePrev && !s.sync2) begin
                    next_s.st = LINK_RX;
                end
            end
            LINK_TX: begin
                if (endBit) begin
                    if (s.bitIdx < SLOT_PARITY) begin
                        next_s.drvLow  = ~s.shifter[0];
                        next_s.shifter = {1'b0, s.shifter[8:1]};
                    end else begin
                        next_s.drvLow = 1'b0;
                    end
                end
                // Error signal sampled mid first guard slot
                if (midBit && s.bitIdx == SLOT_SIGNAL) begin
                    next_s.err = ~s.sync2;
                end
                if (endBit && s.bitIdx == SLOT_LAST) begin
                    next_s.st = LINK_IDLE;
                    if (s.err && s.cardMode) begin
                        set[ST_NACK] = 1'b1;
                    end else begin
                        set[ST_TXEMPTY] = 1'b1;
                        set[ST_TXDONE]  = 1'b1;
                    end
                end
            end
            LINK_RX: begin
                if (midBit && s.bitIdx != 4'd0 && s.bitIdx <= SLOT_PARITY) begin
                    next_s.shifter = {s.sync2, s.shifter[8:1]};
                end
                // False start: line high again mid start bit
                if (midBit && s.bitIdx == 4'd0 && s.sync2) begin
                    next_s.st = LINK_IDLE;
                end
                if (midBit && s.bitIdx == SLOT_PARITY) begin
                    parOk = (s.sync2 == charParity(s.shifter[8:1],
                                                   s.fmt[FM_ODD]));
                    next_s.err = ~parOk;
                    if (s.flags[ST_RXFULL]) begin
                        set[ST_OVERRUN] = 1'b1;
                    end else begin
                        // data kept even on parity error
                        next_s.rx_holding_reg = s.shifter[8:1];
                        // no full flag on parity error
                        set[ST_RXFULL] = parOk;
                        set[ST_PARITY] = ~parOk;
                    end
                end
                if (midBit && s.bitIdx == SLOT_SIGNAL) begin
                    // error signal from 10.5 etu for 1 etu
                    next_s.drvLow = s.err & s.cardMode;
                    set[ST_FRAMING] = ~s.cardMode & ~s.sync2;
                end
                if (midBit && s.bitIdx == SLOT_LAST) begin
                    next_s.drvLow = 1'b0;
                    next_s.st     = LINK_IDLE;
                end
            end
            default: next_s.st = LINK_IDLE;
        endcase

        // Hardware set wins over any clear in the same cycle
        next_s.flags = (s.flags & ~clr) | set;

        // Transmitter off abandons a frame at once
        if (!s.ctl[CT_TXON] && s.st == LINK_TX) begin
            next_s.st     = LINK_IDLE;
            next_s.drvLow = 1'b0;
        end
        // Receiver off abandons a frame and lets go of the line
        if (!s.ctl[CT_RXON] && s.st == LINK_RX) begin
            next_s.st     = LINK_IDLE;
            next_s.drvLow = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s          <= '0;
            s.fmt      <= RST_FORMAT;
            s.ctl      <= RST_CONTROL;
            s.flags    <= RST_STATUS;
            s.div      <= RST_DIVIDER;
            s.sync1    <= 1'b1;
            s.sync2    <= 1'b1;
            s.linePrev <= 1'b1;
            s.st       <= LINK_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o    = s.ack;
    assign wb_dat_o    = {24'h000000, s.rdat};
    assign rxData      = s.rx_holding_reg;
    // Open drain line: only the enable moves
    assign cardDataOut = 1'b0;
    assign cardDataOe  = s.drvLow;
    // idle level bit fixes the stopped clock
    assign cardClk     = s.sckRun ? s.sckPh : s.ctl[CT_IDLELVL];

    // normal mode transmit request follows empty flag
    // card mode transmit request follows done flag
    assign txReqRaw   = s.cardMode ? s.flags[ST_TXDONE]
                                   : s.flags[ST_TXEMPTY];
    assign txEmptyIrq = s.ctl[CT_TXIRQ] & txReqRaw;
    // done irq only when no transmit request
    assign txDoneIrq  = ~s.cardMode & s.ctl[CT_DONEIRQ]
                        & s.flags[ST_TXDONE] & ~txEmptyIrq;
    assign rxFullIrq  = s.ctl[CT_RXIRQ] & s.flags[ST_RXFULL];
    // fault irq never requests the engine
    assign faultAny   = s.flags[ST_OVERRUN] | s.flags[ST_PARITY]
                        | s.flags[ST_FRAMING]
                        | (s.cardMode & s.flags[ST_NACK]);
    assign rxFaultIrq = s.ctl[CT_RXIRQ] & faultAny;
    assign engTxReq   = txEmptyIrq;
    assign engRxReq   = rxFullIrq;
endmodule : scx_card_serial
`default_nettype wire

//--- logic/scx_pkg.sv
// Constants and types of the smart card serial transmitter and receiver
// Notes on behaviour
// - In card mode, card error signal after a sent frame sets nack flag; fault irq if enabled.
// - Errored frame leaves done flag clear and keeps holding byte for resend.
// - Frame without error signal sets done flag; transmit irq if enabled.
// - In card mode empty and done flags set together, sourcing transmit irq.
// - Transfer engine write of transmit data clears empty and done flags.
// - During resend the done flag stays 0, so no engine request.
// - Writing the next byte after done starts its transmission.
// - Receive parity error sets parity flag; fault irq if receive irq enabled.
// - A frame with parity error does not set the receive-full flag.
// - Good parity sets receive-full flag; full irq when receive irq enabled.
// - Byte with parity error is still moved into the receive holding register.
// - Overrun or parity error raises fault irq, no engine request; byte skipped on overrun only.
// - In hold mode the two clock bits fix the card clock level safely.
// - In hold mode, clock stop finishes the current period, then holds idle level.
// - Clock start gives a full-width first pulse.
// - Normal mode: transmit irq on empty flag, full irq on full flag.
// - Normal mode: fault irq on overrun, parity or framing flag.
// - Done irq only with flag and enable; transmit irq wins on coincidence.
// - Card mode: no done irq, transmit irq on done, fault covers nack.
// - In card mode, receive parity error drives line low 1 etu from 10.5 etu.
// - Transmit keeps at least 2 etu guard after parity.
// - Frame is start, 8 data bits and parity bit.
// - Basic clock is 32, 64, 372 or 256 per bit, mid-bit sampling.
package scx_pkg;
    localparam logic [2:0] ADR_FORMAT  = 3'h0;
    localparam logic [2:0] ADR_CONTROL = 3'h1;
    localparam logic [2:0] ADR_TXHOLD  = 3'h2;
    localparam logic [2:0] ADR_STATUS  = 3'h3;
    localparam logic [2:0] ADR_RXHOLD  = 3'h4;
    localparam logic [2:0] ADR_CARD    = 3'h5;
    localparam logic [2:0] ADR_DIVIDER = 3'h6;

    // Status bit positions
    localparam int ST_TXEMPTY = 7;
    localparam int ST_RXFULL  = 6;
    localparam int ST_OVERRUN = 5;
    localparam int ST_FRAMING = 4;
    localparam int ST_PARITY  = 3;
    localparam int ST_TXDONE  = 2;
    localparam int ST_NACK    = 1;
    // Control bit positions
    localparam int CT_TXIRQ   = 7;
    localparam int CT_RXIRQ   = 6;
    localparam int CT_TXON    = 5;
    localparam int CT_RXON    = 4;
    localparam int CT_DONEIRQ = 2;
    localparam int CT_IDLELVL = 1;
    localparam int CT_CLKON   = 0;
    // Format bit positions
    localparam int FM_HOLD    = 7;
    localparam int FM_ODD     = 5;

    localparam logic [7:0] RST_STATUS  = 8'h84;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_FORMAT  = 8'h00;
    localparam logic [7:0] RST_DIVIDER = 8'h03;

    // Basic clock cycles per bit for each ratio code
    localparam logic [9:0] RATIO_0 = 10'd32;
    localparam logic [9:0] RATIO_1 = 10'd64;
    localparam logic [9:0] RATIO_2 = 10'd372;
    localparam logic [9:0] RATIO_3 = 10'd256;

    // Bit slots of a frame, counted from the start bit
    localparam logic [3:0] SLOT_PARITY = 4'd9;
    localparam logic [3:0] SLOT_SIGNAL = 4'd10;
    localparam logic [3:0] SLOT_LAST   = 4'd11;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_TX,
        LINK_RX
    } scx_link_t;
endpackage : scx_pkg

//--- tb/scx_card_serial_assertions.sv
// Port checker for the smart card serial block
`timescale 1ns/1ps
`default_nettype none
module scx_card_checker (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic engTxWrite,
    input wire logic engRxRead,
    input wire logic txEmptyIrq,
    input wire logic txDoneIrq,
    input wire logic rxFullIrq,
    input wire logic rxFaultIrq,
    input wire logic engTxReq,
    input wire logic engRxReq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    eng_req_a: assert property (
        engTxReq == txEmptyIrq && engRxReq == rxFullIrq)
        else $error("engine request mismatch");
    tx_win_a: assert property (txDoneIrq |-> !txEmptyIrq)
        else $error("done irq beside tx irq");
    tx_clear_a: assert property (
        engTxWrite |=> !txEmptyIrq && !txDoneIrq)
        else $error("engine write left tx irq");
    rx_clear_a: assert property (engRxRead |=> !rxFullIrq)
        else $error("engine read left full irq");
    fault_full_a: assert property (
        $rose(rxFaultIrq) && !wb_cyc_i && !$past(wb_cyc_i) |-> !$rose(rxFullIrq))
        else $error("fault and full together");
    fault_done_a: assert property (
        $rose(rxFaultIrq) && !wb_cyc_i && !$past(wb_cyc_i) |-> !$rose(txEmptyIrq))
        else $error("fault and tx irq together");
    cover property ($rose(rxFaultIrq));
    cover property ($rose(txEmptyIrq));
    cover property ($fell(rxFullIrq));
endmodule : scx_card_checker
bind scx_card_serial scx_card_checker i_scx_card_checker (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .engTxWrite(engTxWrite),
    .engRxRead(engRxRead), .txEmptyIrq(txEmptyIrq), .txDoneIrq(txDoneIrq),
    .rxFullIrq(rxFullIrq), .rxFaultIrq(rxFaultIrq), .engTxReq(engTxReq),
    .engRxReq(engRxReq)
);
`default_nettype wire

//--- tb/scx_card_model.sv
// Behavioural smart card on the shared data line
`timescale 1ns/1ps
`default_nettype none
module scx_card_model #(
    parameter int ETU = 64
) (
    input  wire logic core_clk,
    input  wire logic cardLine,
    output var logic  cardOe
);
    logic [8:0] bits;
    logic [7:0] lastByte;
    logic       parityOk;
    logic       sawNack;
    logic       sending = 1'h0;
    int         nackLeft = 0;
    int         rxCount = 0;
    int         cyc = 0;
    int         lastStart = 0;
    int         prevStart = 0;
    initial cardOe = 1'h0;
    always @(posedge core_clk) cyc <= cyc + 1;
    // Take a frame from the block, refuse it on request
    always begin
        @(posedge core_clk);
        if (!sending && cardLine === 1'h0) begin
            prevStart = lastStart;
            lastStart = cyc;
            repeat (ETU / 2) @(posedge core_clk);
            for (int i = 0; i < 9; i++) begin
                repeat (ETU) @(posedge core_clk);
                bits[i] = cardLine;
            end
            lastByte = bits[7:0];
            parityOk = ~^bits;
            rxCount++;
            repeat (ETU / 2) @(posedge core_clk);
            if (nackLeft > 0) begin
                nackLeft--;
                cardOe <= 1'h1;
            end
            repeat (ETU) @(posedge core_clk);
            cardOe <= 1'h0;
            repeat (ETU / 2) @(posedge core_clk);
        end
    end
    // Send one frame, even parity unless spoiled
    task automatic sendByte(input logic [7:0] d, input logic badPar);
        logic [9:0] f;
        f = {(^d) ^ badPar, d, 1'h0};
        @(posedge core_clk);
        sending = 1'h1;
        for (int i = 0; i < 10; i++) begin
            cardOe <= ~f[i];
            repeat (ETU) @(posedge core_clk);
        end
        cardOe <= 1'h0;
        repeat (ETU * 3 / 4) @(posedge core_clk);
        sawNack = (cardLine === 1'h0);
        repeat (ETU) @(posedge core_clk);
        sending = 1'h0;
    endtask : sendByte
endmodule : scx_card_model
`default_nettype wire

//--- tb/tb_scx_card_serial.sv
// Self-checking bench for the smart card serial block
`timescale 1ns/1ps
`default_nettype none
module tb_scx_card_serial;
    import scx_pkg::*;
    localparam int ETU = 64;
    logic        core_clk, reset, wbCyc, wbStb, wbWe, wbAck;
    logic        engTxWrite, engRxRead, rxFullIrq, rxFaultIrq, mdlOe;
    logic        txEmptyIrq, txDoneIrq, engTxReq, engRxReq;
    logic        cardDataOut, cardDataOe, cardClk;
    logic [4:0]  wbAdr;
    logic [31:0] wbDat, wbDatO;
    logic [7:0]  engTxData, rxData, q;
    wire         cardLine;
    int          errorCnt = 0;
    int          nChecks = 0;
    int          n;
    assign cardLine = (cardDataOe ? cardDataOut : 1'h1) & ~mdlOe;
    scx_card_serial i_scx_card_serial (
        .core_clk(core_clk), .reset(reset), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .engTxWrite(engTxWrite), .engTxData(engTxData),
        .engRxRead(engRxRead), .rxData(rxData), .txEmptyIrq(txEmptyIrq),
        .txDoneIrq(txDoneIrq), .rxFullIrq(rxFullIrq), .rxFaultIrq(rxFaultIrq),
        .engTxReq(engTxReq), .engRxReq(engRxReq), .cardDataIn(cardLine),
        .cardDataOut(cardDataOut), .cardDataOe(cardDataOe), .cardClk(cardClk)
    );
    scx_card_model #(.ETU(ETU)) i_card (
        .core_clk(core_clk), .cardLine(cardLine), .cardOe(mdlOe)
    );
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic chk(input string w, input logic [7:0] e, g);
        nChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
    endtask : tick
    task automatic bus(input logic we, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDat} <= {2'h3, we, a, 2'h0, 24'h0, d};
        @(posedge core_clk);
        for (n = 0; n < 20 && wbAck !== 1'h1; n++) @(posedge core_clk);
        q = wbDatO[7:0];
        {wbCyc, wbStb} <= 2'h0;
        chk("bus ack", 8'h1, wbAck);
    endtask : bus
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'h1, a, d);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string w);
        bus(1'h0, a, 8'h0);
        chk(w, e, q);
    endtask : rd
    task automatic engWrite(input logic [7:0] d);
        @(posedge core_clk);
        {engTxWrite, engTxData} <= {1'h1, d};
        @(posedge core_clk);
        engTxWrite <= 1'h0;
    endtask : engWrite
    task automatic engRx();
        @(posedge core_clk);
        engRxRead <= 1'h1;
        @(posedge core_clk);
        engRxRead <= 1'h0;
        tick(1);
    endtask : engRx
    task automatic waitTx();
        for (n = 0; n < 30 * ETU && txEmptyIrq !== 1'h1; n++) tick(1);
    endtask : waitTx
    task automatic testSetup();
        rd(ADR_STATUS, RST_STATUS, "status reset");
        rd(ADR_DIVIDER, RST_DIVIDER, "divider reset");
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00, "unmapped");
        wr(ADR_CONTROL, 8'h84);
        tick(1);
        chk("tx irq", 8'h1, txEmptyIrq);
        chk("done irq", 8'h0, txDoneIrq);
        wr(ADR_CONTROL, 8'h04);
        tick(1);
        chk("done irq", 8'h1, txDoneIrq);
        // level first, then modes, then clock
        wr(ADR_CONTROL, 8'h00);
        wr(ADR_DIVIDER, 8'h00);
        wr(ADR_FORMAT, 8'h80);
        wr(ADR_CARD, 8'h01);
        wr(ADR_CONTROL, 8'hE1);
        tick(1);
        chk("card tx irq", 8'h1, txEmptyIrq);
        chk("card done irq", 8'h0, txDoneIrq);
        $display("setup test ended");
    endtask : testSetup
    task automatic testTx();
        engWrite(8'hA5);
        tick(1);
        chk("empty cleared", 8'h0, txEmptyIrq);
        waitTx();
        chk("sent byte", 8'hA5, i_card.lastByte);
        chk("parity", 8'h1, i_card.parityOk);
        chk("tx irq", 8'h1, txEmptyIrq);
        rd(ADR_STATUS, 8'h84, "empty and done");
        i_card.nackLeft = 1;
        engWrite(8'h3C);
        for (n = 0; n < 20 * ETU && rxFaultIrq !== 1'h1; n++) tick(1);
        chk("nack fault", 8'h1, rxFaultIrq);
        chk("no engine req", 8'h0, engTxReq);
        rd(ADR_STATUS, 8'h02, "nack status");
        wr(ADR_STATUS, 8'hFD);
        tick(1);
        chk("nack cleared", 8'h0, rxFaultIrq);
        waitTx();
        chk("resent byte", 8'h3C, i_card.lastByte);
        chk("frames", 8'h3, 8'(i_card.rxCount));
        n = i_card.lastStart - i_card.prevStart;
        chk("guard", 8'h1, n > 12 * ETU - 3);
        $display("tx test ended");
    endtask : testTx
    task automatic testRx();
        wr(ADR_CONTROL, 8'h51);
        i_card.sendByte(8'h5A, 1'h0);
        chk("rx full", 8'h1, rxFullIrq);
        chk("rx data", 8'h5A, rxData);
        chk("no signal", 8'h0, i_card.sawNack);
        engRx();
        chk("full cleared", 8'h0, rxFullIrq);
        i_card.sendByte(8'hC3, 1'h1);
        chk("parity full", 8'h0, rxFullIrq);
        chk("parity fault", 8'h1, rxFaultIrq);
        chk("no rx req", 8'h0, engRxReq);
        chk("errored data", 8'hC3, rxData);
        chk("error signal", 8'h1, i_card.sawNack);
        rd(ADR_STATUS, 8'h8C, "parity status");
        wr(ADR_STATUS, 8'hF7);
        i_card.sendByte(8'h11, 1'h0);
        i_card.sendByte(8'h22, 1'h0);
        chk("overrun fault", 8'h1, rxFaultIrq);
        chk("kept data", 8'h11, rxData);
        rd(ADR_STATUS, 8'hE4, "overrun status");
        wr(ADR_STATUS, 8'hDF);
        engRx();
        $display("rx test ended");
    endtask : testRx
    task automatic testClock();
        // link off with level set, then clock off, then wait
        wr(ADR_CONTROL, 8'h03);
        wr(ADR_CONTROL, 8'h02);
        tick(8);
        chk("held high", 8'h1, cardClk);
        tick(8);
        chk("still high", 8'h1, cardClk);
        wr(ADR_CONTROL, 8'h03);
        n = 0;
        repeat (16) begin
            @(posedge core_clk);
            n += cardClk;
        end
        chk("running", 8'h1, n > 4 && n < 12);
        wr(ADR_CONTROL, 8'h00);
        tick(8);
        chk("held low", 8'h0, cardClk);
        $display("clock test ended");
    endtask : testClock
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tallyAndFinish
    initial begin
        {wbCyc, wbStb, wbWe, wbAdr, wbDat} = '0;
        {engTxWrite, engTxData, engRxRead} = '0;
        reset = 1'h1;
        repeat (16) @(posedge core_clk);
        reset <= 1'h0;
        testSetup();
        testTx();
        testRx();
        testClock();
        tallyAndFinish();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        errorCnt++;
        tallyAndFinish();
    end
endmodule : tb_scx_card_serial
`default_nettype wire
